// >>> src/scr_rom_layer.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [RL1] CCh skips straight to memory functions
// [RL2] A5h proceeds only if resume flag set
// [RL3] Resume flag set by match/search/OD-match
// [RL4] Addressing another device clears resume flag
// [RL5] 3Ch sets overdrive, then memory functions
// [RL6] Reset of 480us clears overdrive
// [RL7] Master resets at overdrive before addressing
// [RL8] 69h: identifier at overdrive, match selects
// [RL9] Overdrive kept when OD-match misses
// [RL10] Master avoids reads after skip, multidrop
// [RL11] Shallow dips within hysteresis ignored
// [RL12] Glitches inside hold-off window ignored
// [RL13] Late or long lows start slots
// [RL14] Commands are exactly eight bits
// [RL15] 55h: only exact identifier match answers
// [RL16] Least significant bit first, one per slot
module scr_rom_layer
  import scr_pkg::*;
#(
  parameter logic [63:0] ROM_ID = 64'h0123456789ABCDEF, // Arbitrary value
  parameter int RST_LONG_CYC = SCR_RST_LONG_CYC,
  parameter int HOLDOFF_CYC = SCR_HOLDOFF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic above_upper_i,
  input wire logic below_hyst_i,
  output logic line_oe_o,
  output logic line_o,
  output logic mem_go_o,
  input wire logic mem_done_i,
  output var scr_status_t status_o
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CMD = 6'b000010,
    ST_MATCH = 6'b000100,
    ST_SRCH = 6'b001000,
    ST_MEM = 6'b010000,
    ST_WAIT = 6'b100000
  } scr_state_t;

  scr_edge_t edge_s;
  scr_state_t st_reg, st_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [6:0] bit_reg, bit_next;
  logic [1:0] tri_reg, tri_next;
  logic [SCR_CNT_W-1:0] low_reg, low_next;
  logic [SCR_CNT_W-1:0] slot_reg, slot_next;
  logic ok_reg, ok_next, rc_reg, rc_next, od_reg, od_next, odm_reg, odm_next;
  logic pres_reg, pres_next, drv_reg, drv_next, go_reg, go_next;
  logic [SCR_CNT_W-1:0] low_lim, rst_lim, rd_lim;
  logic id_bit, sample, rst_seen, rst_long;
  logic [SCR_CNT_W-1:0] age_reg, age_next;
  logic spd_reg, spd_next, mfall;

  scr_frontend #(.HOLDOFF_CYC(HOLDOFF_CYC)) u_fe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .above_upper_i(above_upper_i),
    .below_hyst_i(below_hyst_i),
    .edge_o(edge_s)
  );

  function automatic logic [SCR_CNT_W-1:0] pick(input logic od, input int fast, input int slow);
    pick = od ? fast[SCR_CNT_W-1:0] : slow[SCR_CNT_W-1:0];
  endfunction : pick

  // Speed latched per slot, so a mid-slot switch cannot cut it short
  assign low_lim = pick(spd_reg, SCR_OD_SAMPLE_CYC, SCR_STD_SAMPLE_CYC);
  assign rst_lim = pick(spd_reg, SCR_OD_RESET_CYC, SCR_STD_RESET_CYC);
  assign rd_lim = pick(spd_reg, SCR_OD_READ_CYC, SCR_STD_READ_CYC);
  assign id_bit = ROM_ID[bit_reg[5:0]]; // RL16
  // Own pulldown is no master fall
  assign mfall = edge_s.fall && !drv_reg;
  assign sample = age_reg == low_lim - 16'h0001;
  assign rst_seen = edge_s.rise && low_reg >= rst_lim;
  assign rst_long = edge_s.rise && low_reg >= RST_LONG_CYC[SCR_CNT_W-1:0];

  always_comb begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    bit_next = bit_reg;
    tri_next = tri_reg;
    ok_next = ok_reg;
    rc_next = rc_reg;
    od_next = od_reg;
    odm_next = odm_reg;
    pres_next = 1'b0;
    drv_next = drv_reg;
    go_next = 1'b0;
    low_next = edge_s.level ? 16'h0000 : low_reg + 16'h0001;
    // Slot timer from master fall, whatever the line does later
    age_next = (age_reg != 16'h0000 && age_reg < low_lim) ? age_reg + 16'h0001 : 16'h0000;
    spd_next = spd_reg;
    slot_next = (slot_reg != 16'h0000) ? slot_reg - 16'h0001 : slot_reg;
    if (slot_reg == 16'h0001) begin
      drv_next = 1'b0;
    end
    if (mfall) begin
      drv_next = 1'b0;
      age_next = 16'h0001;
      spd_next = od_reg;
    end
    if (rst_seen) begin
      st_next = ST_CMD;
      bit_next = 7'h00;
      cmd_next = 8'h00;
      pres_next = 1'b1;
      spd_next = rst_long ? 1'b0 : od_reg;
      if (rst_long) begin
        od_next = 1'b0; // RL6
      end
    end else if (mfall && (st_reg == ST_SRCH) && tri_reg != 2'd2) begin
      drv_next = (tri_reg == 2'd0) ? !id_bit : id_bit; // RL16
      slot_next = rd_lim;
    end else if (sample) begin
      case (st_reg)
        ST_CMD: begin
          cmd_next = {edge_s.level, cmd_reg[7:1]}; // RL16
          bit_next = bit_reg + 7'h01;
          if (bit_reg == 7'(SCR_CMD_BITS - 1)) begin // RL14
            bit_next = 7'h00;
            ok_next = 1'b1;
            tri_next = 2'd0;
            case ({edge_s.level, cmd_reg[7:1]})
              SCR_CMD_SKIP: begin
                st_next = ST_MEM; // RL1
                rc_next = 1'b0; // RL4
                go_next = 1'b1;
              end
              SCR_CMD_RESUME: begin
                st_next = rc_reg ? ST_MEM : ST_WAIT; // RL2
                go_next = rc_reg;
              end
              SCR_CMD_OD_SKIP: begin
                od_next = 1'b1; // RL5
                rc_next = 1'b0;
                st_next = ST_MEM;
                go_next = 1'b1;
              end
              SCR_CMD_MATCH: begin
                odm_next = 1'b0;
                st_next = ST_MATCH;
              end
              SCR_CMD_OD_MATCH: begin
                odm_next = 1'b1;
                od_next = 1'b1; // RL8
                st_next = ST_MATCH;
              end
              SCR_CMD_SEARCH: st_next = ST_SRCH;
              default: st_next = ST_WAIT;
            endcase
          end
        end
        ST_MATCH: begin
          if (edge_s.level != id_bit) begin
            ok_next = 1'b0; // RL15
          end
          bit_next = bit_reg + 7'h01;
          if (bit_reg == 7'(SCR_ID_BITS - 1)) begin
            if (ok_reg && edge_s.level == id_bit) begin
              st_next = ST_MEM;
              rc_next = 1'b1; // RL3
              go_next = 1'b1;
            end else begin
              st_next = ST_WAIT;
              rc_next = 1'b0; // RL4
              od_next = odm_reg ? od_reg : od_reg; // RL9
            end
          end
        end
        ST_SRCH: begin
          if (tri_reg == 2'd2) begin
            tri_next = 2'd0;
            bit_next = bit_reg + 7'h01;
            if (edge_s.level != id_bit) begin
              st_next = ST_WAIT;
              rc_next = 1'b0; // RL4
            end else if (bit_reg == 7'(SCR_ID_BITS - 1)) begin
              st_next = ST_MEM;
              rc_next = 1'b1; // RL3
              go_next = 1'b1;
            end
          end else begin
            tri_next = tri_reg + 2'd1;
          end
        end
        ST_MEM: begin
          if (mem_done_i) begin
            st_next = ST_WAIT;
          end
        end
        default: ;
      endcase
    end
    if (pres_reg) begin
      drv_next = 1'b1;
      slot_next = rd_lim << 1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= ST_IDLE;
      cmd_reg <= 8'h00;
      bit_reg <= 7'h00;
      tri_reg <= 2'd0;
      low_reg <= 16'h0000;
      age_reg <= 16'h0000;
      spd_reg <= 1'b0;
      slot_reg <= 16'h0000;
      ok_reg <= 1'b0;
      rc_reg <= 1'b0;
      od_reg <= 1'b0;
      odm_reg <= 1'b0;
      pres_reg <= 1'b0;
      drv_reg <= 1'b0;
      go_reg <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      bit_reg <= bit_next;
      tri_reg <= tri_next;
      low_reg <= low_next;
      age_reg <= age_next;
      spd_reg <= spd_next;
      slot_reg <= slot_next;
      ok_reg <= ok_next;
      rc_reg <= rc_next;
      od_reg <= od_next;
      odm_reg <= odm_next;
      pres_reg <= pres_next;
      drv_reg <= drv_next;
      go_reg <= go_next;
    end
  end

  assign line_o = 1'b0;
  assign line_oe_o = drv_reg;
  assign mem_go_o = go_reg;
  assign status_o = '{resume_flag: rc_reg, overdrive_flag: od_reg, selected: st_reg == ST_MEM};

  chk_skip_to_mem: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_reg == ST_CMD && sample && bit_reg == 7'd7 && {edge_s.level, cmd_reg[7:1]} == SCR_CMD_SKIP
    |=> st_reg == ST_MEM && mem_go_o) // RL1
    else $error("Skip did not enter memory functions");
  chk_resume_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_reg == ST_CMD && sample && bit_reg == 7'd7 && {edge_s.level, cmd_reg[7:1]} == SCR_CMD_RESUME
    |=> (st_reg == ST_MEM) == $past(rc_reg)) // RL2
    else $error("Resume ignored resume flag");
  chk_rc_set_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(rc_reg) |-> $past(st_reg) == ST_MATCH || $past(st_reg) == ST_SRCH) // RL3
    else $error("Resume flag set without identifier match");
  chk_od_skip_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_reg == ST_CMD && sample && bit_reg == 7'd7 && {edge_s.level, cmd_reg[7:1]} == SCR_CMD_OD_SKIP
    |=> od_reg && !rc_reg) // RL5
    else $error("Overdrive skip did not set overdrive");
  chk_long_reset_od: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rst_long |=> !od_reg && st_reg == ST_CMD) // RL6
    else $error("Long reset kept overdrive");
  chk_od_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    od_reg && !(ce_i && rst_long) |=> od_reg) // RL9
    else $error("Overdrive dropped without long reset");
  chk_match_miss: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ST_MATCH && !ok_reg |=> st_reg != ST_MEM) // RL15
    else $error("Mismatched identifier selected");
  chk_cmd_len: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ST_CMD |-> bit_reg < 7'd8) // RL14
    else $error("Command longer than eight bits");
endmodule : scr_rom_layer
`default_nettype wire

// >>> src/scr_pkg.sv
package scr_pkg;
  localparam logic [7:0] SCR_CMD_READ = 8'h33;
  localparam logic [7:0] SCR_CMD_MATCH = 8'h55;
  localparam logic [7:0] SCR_CMD_SEARCH = 8'hF0;
  localparam logic [7:0] SCR_CMD_SKIP = 8'hCC;
  localparam logic [7:0] SCR_CMD_RESUME = 8'hA5;
  localparam logic [7:0] SCR_CMD_OD_SKIP = 8'h3C;
  localparam logic [7:0] SCR_CMD_OD_MATCH = 8'h69;
  localparam int SCR_CMD_BITS = 8;
  localparam int SCR_ID_BITS = 64;
  localparam int SCR_CLK_MHZ = 25;
  localparam int SCR_RST_LONG_US = 480;
  localparam int SCR_RST_LONG_CYC = SCR_RST_LONG_US * SCR_CLK_MHZ;
  localparam int SCR_STD_SAMPLE_NS = 30000;
  localparam int SCR_OD_SAMPLE_NS = 3000;
  localparam int SCR_STD_RESET_NS = 240000;
  localparam int SCR_OD_RESET_NS = 24000;
  localparam int SCR_STD_READ_NS = 30000;
  localparam int SCR_OD_READ_NS = 3000;
  localparam int SCR_HOLDOFF_NS = 1000;
  localparam int SCR_CLK_NS = 1000 / SCR_CLK_MHZ;
  localparam int SCR_STD_SAMPLE_CYC = SCR_STD_SAMPLE_NS / SCR_CLK_NS;
  localparam int SCR_OD_SAMPLE_CYC = SCR_OD_SAMPLE_NS / SCR_CLK_NS;
  localparam int SCR_STD_RESET_CYC = SCR_STD_RESET_NS / SCR_CLK_NS;
  localparam int SCR_OD_RESET_CYC = SCR_OD_RESET_NS / SCR_CLK_NS;
  localparam int SCR_STD_READ_CYC = SCR_STD_READ_NS / SCR_CLK_NS;
  localparam int SCR_OD_READ_CYC = SCR_OD_READ_NS / SCR_CLK_NS;
  localparam int SCR_HOLDOFF_CYC = (SCR_HOLDOFF_NS + SCR_CLK_NS - 1) / SCR_CLK_NS;
  localparam int SCR_CNT_W = 16;

  typedef struct packed {
    logic fall;
    logic rise;
    logic level;
  } scr_edge_t;

  typedef struct packed {
    logic resume_flag;
    logic overdrive_flag;
    logic selected;
  } scr_status_t;
endpackage : scr_pkg

// >>> src/scr_frontend.sv
`timescale 1ns/100ps
`default_nettype none
module scr_frontend
  import scr_pkg::*;
#(
  parameter int HOLDOFF_CYC = SCR_HOLDOFF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic above_upper_i,
  input wire logic below_hyst_i,
  output var scr_edge_t edge_o
);
  logic level_reg, level_next;
  logic [SCR_CNT_W-1:0] hold_reg, hold_next;
  logic fall_reg, fall_next, rise_reg, rise_next;

  always_comb begin
    level_next = level_reg;
    hold_next = hold_reg;
    fall_next = 1'b0;
    rise_next = 1'b0;
    if (level_reg) begin
      if (hold_reg != 16'h0000) begin
        hold_next = hold_reg - 16'h0001; // RL12
      end
      if (below_hyst_i) begin // RL11
        if (hold_reg == 16'h0000) begin // RL13
          level_next = 1'b0;
          fall_next = 1'b1;
        end
      end
    end else if (above_upper_i) begin
      level_next = 1'b1;
      rise_next = 1'b1;
      hold_next = HOLDOFF_CYC[SCR_CNT_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_reg <= 1'b1;
      hold_reg <= 16'h0000;
      fall_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else if (ce_i) begin
      level_reg <= level_next;
      hold_reg <= hold_next;
      fall_reg <= fall_next;
      rise_reg <= rise_next;
    end
  end

  assign edge_o = '{fall: fall_reg, rise: rise_reg, level: level_reg};

  chk_holdoff_masks_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && level_reg && hold_reg != 16'h0000 |=> level_reg) // RL12
    else $error("Fall taken inside hold-off window");
  chk_hyst_ignores_dip: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && level_reg && !below_hyst_i |=> level_reg) // RL11
    else $error("Shallow dip taken as fall");
  chk_late_fall_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && level_reg && hold_reg == 16'h0000 && below_hyst_i |=> !level_reg && fall_reg) // RL13
    else $error("Fall after window missed");
endmodule : scr_frontend
`default_nettype wire

// >>> verif/scr_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module scr_master_model (
  input wire logic clk_i,
  input wire logic dev_pull_i,
  output logic above_upper_o,
  output logic below_hyst_o
);
  logic pull_low = 1'b0;
  logic dip = 1'b0;
  logic line;

  // Wired line with pull-up
  assign line = !(pull_low || dev_pull_i);
  assign above_upper_o = line && !dip;
  assign below_hyst_o = !line;

  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hold

  // Reset low, then wait out presence
  task automatic bus_reset(input int low_cyc, input int wait_cyc);
    pull_low = 1'b1;
    hold(low_cyc);
    pull_low = 1'b0;
    hold(wait_cyc);
  endtask : bus_reset

  // One write slot; glitches on the high phase of a one
  task automatic write_slot(input logic b, input int s, input logic glitch);
    int low_c;
    low_c = b ? 3 : s + 10;
    pull_low = 1'b1;
    hold(low_c);
    pull_low = 1'b0;
    if (glitch && b) begin
      hold(8);
      pull_low = 1'b1;
      hold(5);
      pull_low = 1'b0;
      hold(20);
      dip = 1'b1;
      hold(20);
      dip = 1'b0;
      hold(s - 3 - low_c);
    end else begin
      hold(s + 50 - low_c);
    end
  endtask : write_slot

  // One read slot: short low, then look at the line
  task automatic read_slot(input int s, output logic b);
    pull_low = 1'b1;
    hold(3);
    pull_low = 1'b0;
    hold(10);
    b = line;
    hold(s + 37);
  endtask : read_slot

  // Write slots only, n bits per call (down to one), low bit first
  task automatic send(input logic [63:0] v, input int n, input int s, input logic glitch);
    for (int i = 0; i < n; i++) begin
      write_slot(v[i], s, glitch);
    end
  endtask : send
endmodule : scr_master_model
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module tb;
  import scr_pkg::*;
  localparam logic [63:0] TB_ID = 64'h5A3C96E10F872D4B; // Arbitrary value
  localparam int S_STD = SCR_STD_SAMPLE_CYC;
  localparam int S_OD = SCR_OD_SAMPLE_CYC;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic above_upper;
  logic below_hyst;
  logic line_oe;
  logic mem_go;
  scr_status_t status;
  int bad_count = 0;
  int total_checks = 0;
  int go_count = 0;
  int gd;

  always #20 clk = ~clk;
  always @(posedge clk) if (mem_go === 1'b1) go_count++;

  scr_rom_layer #(.ROM_ID(TB_ID), .RST_LONG_CYC(SCR_RST_LONG_CYC), .HOLDOFF_CYC(SCR_HOLDOFF_CYC)) dut_u (
    .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .above_upper_i(above_upper), .below_hyst_i(below_hyst),
    .line_oe_o(line_oe), .line_o(), .mem_go_o(mem_go), .mem_done_i(1'b0), .status_o(status));

  scr_master_model mst_u (.clk_i(clk), .dev_pull_i(line_oe), .above_upper_o(above_upper),
    .below_hyst_o(below_hyst));

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Reset, command, optional identifier; reports memory starts seen
  task automatic run(input int rc, input int wc, input int s, input logic [7:0] cmd,
                     input logic with_id, input logic [63:0] id, input logic gl, output int got);
    int go0;
    go0 = go_count;
    mst_u.bus_reset(rc, wc);
    mst_u.send({56'h0, cmd}, 8, s, gl);
    if (with_id) mst_u.send(id, 64, s, 1'b0);
    got = go_count - go0;
  endtask : run

  task automatic sc_od_skip;
    run(6100, 1700, S_STD, SCR_CMD_OD_SKIP, 1'b0, 64'h0, 1'b0, gd);
    `CHK("od skip start", 1, gd)
    `CHK("od skip status", 3'h3, status)
  endtask : sc_od_skip

  task automatic sc_match;
    run(700, 200, S_OD, SCR_CMD_MATCH, 1'b1, TB_ID, 1'b0, gd);
    `CHK("match start", 1, gd)
    `CHK("match status", 3'h7, status)
  endtask : sc_match

  task automatic sc_resume_hit;
    run(700, 200, S_OD, SCR_CMD_RESUME, 1'b0, 64'h0, 1'b0, gd);
    `CHK("resume start", 1, gd)
    `CHK("resume status", 3'h7, status)
  endtask : sc_resume_hit

  task automatic sc_od_match_miss;
    run(700, 200, S_OD, SCR_CMD_OD_MATCH, 1'b1, TB_ID ^ 64'h8000000000000001, 1'b0, gd);
    `CHK("od match miss start", 0, gd)
    `CHK("od match miss status", 3'h2, status)
  endtask : sc_od_match_miss

  task automatic sc_resume_miss;
    run(700, 200, S_OD, SCR_CMD_RESUME, 1'b0, 64'h0, 1'b0, gd);
    `CHK("resume miss start", 0, gd)
    `CHK("resume miss status", 3'h2, status)
  endtask : sc_resume_miss

  // Search: read true, read complement, write the bit
  task automatic sc_search;
    logic t;
    logic c;
    int go0;
    go0 = go_count;
    mst_u.bus_reset(700, 200);
    mst_u.send({56'h0, SCR_CMD_SEARCH}, 8, S_OD, 1'b0);
    for (int i = 0; i < 64; i++) begin
      mst_u.read_slot(S_OD, t);
      mst_u.read_slot(S_OD, c);
      `CHK("search true bit", TB_ID[i], t)
      `CHK("search complement bit", !TB_ID[i], c)
      mst_u.send({63'h0, TB_ID[i]}, 1, S_OD, 1'b0);
    end
    gd = go_count - go0;
    `CHK("search start", 1, gd)
    `CHK("search status", 3'h7, status)
  endtask : sc_search

  task automatic sc_od_match_hit;
    run(700, 200, S_OD, SCR_CMD_OD_MATCH, 1'b1, TB_ID, 1'b0, gd);
    `CHK("od match start", 1, gd)
    `CHK("od match status", 3'h7, status)
  endtask : sc_od_match_hit

  task automatic sc_glitch;
    run(700, 200, S_OD, SCR_CMD_OD_SKIP, 1'b0, 64'h0, 1'b1, gd);
    `CHK("glitch start", 1, gd)
    `CHK("glitch status", 3'h3, status)
  endtask : sc_glitch

  task automatic sc_long_reset;
    run(12100, 1700, S_STD, SCR_CMD_SKIP, 1'b0, 64'h0, 1'b0, gd);
    `CHK("skip start", 1, gd)
    `CHK("skip status", 3'h1, status)
  endtask : sc_long_reset

  initial begin
    repeat (99000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    sc_od_skip();
    sc_match();
    sc_resume_hit();
    sc_od_match_miss();
    sc_resume_miss();
    sc_search();
    sc_od_match_hit();
    sc_glitch();
    sc_long_reset();
    close_out();
  end
endmodule : tb
`default_nettype wire
